// *** rtl/etb_defs.svh ***
`ifndef ETB_DEFS_SVH
`define ETB_DEFS_SVH
// Register byte addresses
`define ETB_ADDR_CTRL      8'h00
`define ETB_ADDR_ACR       8'h04
`define ETB_ADDR_OPT_NV    8'h08
`define ETB_ADDR_DIVH      8'h0C
`define ETB_ADDR_DIVL      8'h10
`define ETB_ADDR_DIVH_NV   8'h14
`define ETB_ADDR_DIVL_NV   8'h18
`define ETB_ADDR_STATUS    8'h1C
`define ETB_ADDR_SEQ_LEN   8'h20
// Control register fields
`define ETB_CTRL_LAT       0
`define ETB_CTRL_PGM       1
`define ETB_CTRL_VALID     2
`define ETB_CTRL_REFSEL    3
`define ETB_CTRL_TGT_LO    4
`define ETB_CTRL_TGT_HI    5
// Divider high fields
`define ETB_DIVH_SECD      7
// Reset and shipped values
`define ETB_OPT_SHIPPED    8'hF0
`define ETB_DIVH_NV_INIT   8'h80
`define ETB_DIVL_NV_INIT   8'h00
`define ETB_SEQ_LEN_INIT   8'h04
// Program sequence targets
`define ETB_TGT_OPT        2'h0
`define ETB_TGT_DIVH       2'h1
`define ETB_TGT_DIVL       2'h2
// Timebase
`define ETB_TICK_NS        35000
`define ETB_CLK_NS         10
`endif

// *** rtl/etb_pkg.sv ***
`default_nettype none
package etb_pkg;
    typedef enum logic [1:0] {
        ETB_IDLE  = 2'b00,
        ETB_RUN   = 2'b01,
        ETB_HALT  = 2'b10
    } etb_state_type;
endpackage
`default_nettype wire

// *** rtl/etb_timebase_config.sv ***
// The AHB-Lite slave port and the register offsets were left to the implementer.
`include "etb_defs.svh"
`default_nettype none
module etb_timebase_config
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // AHB-Lite slave
    input  wire logic         hsel_i,
    input  wire logic [31:0]  haddr_i,
    input  wire logic [1:0]   htrans_i,
    input  wire logic         hwrite_i,
    input  wire logic [2:0]   hsize_i,
    input  wire logic [31:0]  hwdata_i,
    input  wire logic         hready_i,
    output logic      [31:0]  hrdata_o,
    output logic              hreadyout_o,
    output logic              hresp_o,
    // Reference clock enables and low-power modes
    input  wire logic         xtal_ref_en_i,
    input  wire logic         wait_mode_i,
    input  wire logic         stop_mode_i,
    // Status outputs
    output logic              tick_o,
    output logic              high_voltage_o,
    output logic      [3:0]   block_protect_o,
    output logic              array_secure_o,
    output logic              access_blocked_o
);
    import etb_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0]    opt_nv_r  = `ETB_OPT_SHIPPED;
    logic [7:0]    acr_r;
    logic [7:0]    divh_r;
    logic [7:0]    divl_r;
    logic [7:0]    divh_nv_r = `ETB_DIVH_NV_INIT;
    logic [7:0]    divl_nv_r = `ETB_DIVL_NV_INIT;
    logic [7:0]    seq_len_r;
    logic          lat_r;
    logic          pgm_r;
    logic          valid_r;
    logic          refsel_r;
    logic [1:0]    tgt_r;
    logic [7:0]    wdat_r;
    logic          load_r;
    logic [10:0]   tb_cnt_r;
    logic [7:0]    seq_cnt_r;
    logic          tick_r;
    etb_state_type state_r;
    etb_state_type state_nxt;
    logic          wr_ph_r;
    logic [7:0]    wa_r;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        addr_ph  = hsel_i && hready_i && htrans_i[1];
    wire        wr_en    = wr_ph_r;
    wire [7:0]  wd       = hwdata_i[7:0];
    wire [10:0] divisor  = {divh_r[2:0], divl_r};
    wire        sec_off  = divh_r[`ETB_DIVH_SECD];
    wire        div_wr_ok = !lat_r && sec_off;
    wire        nv_div_ok = sec_off && divh_nv_r[`ETB_DIVH_SECD];
    wire        busy     = (state_r != ETB_IDLE);
    wire        wr_ctrl  = wr_en && (wa_r == `ETB_ADDR_CTRL);
    wire        wr_divh  = wr_en && (wa_r == `ETB_ADDR_DIVH) && div_wr_ok;
    wire        wr_divl  = wr_en && (wa_r == `ETB_ADDR_DIVL) && div_wr_ok;
    wire        wr_seq   = wr_en && (wa_r == `ETB_ADDR_SEQ_LEN);
    wire        pgm_set  = wr_ctrl && wd[`ETB_CTRL_PGM] && lat_r && valid_r;
    wire        tgt_ok   = (tgt_r == `ETB_TGT_OPT) || nv_div_ok;
    wire        cap_opt  = wr_en && lat_r && (wa_r == `ETB_ADDR_OPT_NV);
    wire        cap_dh   = wr_en && lat_r && (wa_r == `ETB_ADDR_DIVH_NV) && nv_div_ok;
    wire        cap_dl   = wr_en && lat_r && (wa_r == `ETB_ADDR_DIVL_NV) && nv_div_ok;
    wire        ref_en   = refsel_r ? 1'b1 : xtal_ref_en_i;
    wire        tb_exp   = ref_en && (tb_cnt_r <= 11'h001);
    wire        seq_done = (state_r == ETB_RUN) && tick_r && (seq_cnt_r <= 8'h01);

    // ------------------------------------------------------------
    // Program sequence state machine
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ETB_IDLE:
            begin
                if (pgm_set && tgt_ok && !stop_mode_i)
                    state_nxt = ETB_RUN;
            end
            ETB_RUN:
            begin
                if (stop_mode_i && lat_r && pgm_r)
                    state_nxt = ETB_HALT;
                else if (stop_mode_i)
                    state_nxt = ETB_IDLE;
                else if (seq_done)
                    state_nxt = ETB_IDLE;
            end
            ETB_HALT:
            begin
                if (!stop_mode_i)
                    state_nxt = ETB_RUN;
            end
            default: state_nxt = ETB_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Bus phase and control
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ph_r <= 1'b0;
            wa_r    <= 8'h00;
        end
        else if (hready_i)
        begin
            wr_ph_r <= addr_ph && hwrite_i;
            wa_r    <= haddr_i[7:0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lat_r    <= 1'b0;
            pgm_r    <= 1'b0;
            refsel_r <= 1'b0;
            tgt_r    <= `ETB_TGT_OPT;
        end
        else
        begin
            if (wr_ctrl)
            begin
                refsel_r <= wd[`ETB_CTRL_REFSEL];
                pgm_r    <= pgm_set;
                lat_r    <= wd[`ETB_CTRL_LAT] || pgm_r;    // Latch held while pgm set
            end
            else if (seq_done || (state_r == ETB_RUN && stop_mode_i && !pgm_r))
                pgm_r <= 1'b0;
            if (cap_opt)
                tgt_r <= `ETB_TGT_OPT;
            else if (cap_dh)
                tgt_r <= `ETB_TGT_DIVH;
            else if (cap_dl)
                tgt_r <= `ETB_TGT_DIVL;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            valid_r <= 1'b0;
            wdat_r  <= 8'h00;
        end
        else if (cap_opt || cap_dh || cap_dl)
        begin
            valid_r <= 1'b1;
            wdat_r  <= wd;
        end
        else if (wr_ctrl && !wd[`ETB_CTRL_LAT] && !pgm_r)
            valid_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Nonvolatile copies, kept across the block reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (seq_done && tgt_r == `ETB_TGT_OPT)
            opt_nv_r <= wdat_r;
        if (seq_done && tgt_r == `ETB_TGT_DIVH && nv_div_ok)
            divh_nv_r <= wdat_r;
        if (seq_done && tgt_r == `ETB_TGT_DIVL && nv_div_ok)
            divl_nv_r <= wdat_r;
    end

    // ------------------------------------------------------------
    // Reset-loaded registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            load_r <= 1'b1;
        else
            load_r <= 1'b0;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            acr_r  <= 8'h00;
            divh_r <= 8'h00;
            divl_r <= 8'h00;
        end
        else if (load_r)
        begin
            acr_r  <= opt_nv_r;
            divh_r <= divh_nv_r;
            divl_r <= divl_nv_r;
        end
        else
        begin
            if (wr_divh)
                divh_r <= wd;
            if (wr_divl)
                divl_r <= wd;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            seq_len_r <= `ETB_SEQ_LEN_INIT;
        else if (wr_seq)
            seq_len_r <= wd;
    end

    // ------------------------------------------------------------
    // Timebase and sequence timer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tb_cnt_r <= 11'h000;
            tick_r   <= 1'b0;
        end
        else
        begin
            tick_r <= tb_exp;
            if (tb_exp)
                tb_cnt_r <= divisor;
            else if (ref_en)
                tb_cnt_r <= tb_cnt_r - 11'h001;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r   <= ETB_IDLE;
            seq_cnt_r <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r == ETB_IDLE || state_nxt == ETB_HALT)
                seq_cnt_r <= seq_len_r;                                 // restart
            else if (state_r == ETB_RUN && tick_r)
                seq_cnt_r <= seq_cnt_r - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Read mux and outputs
    // ------------------------------------------------------------
    logic [7:0] rd_r;
    wire  [7:0] ctrl_rd = {2'b00, tgt_r, refsel_r, valid_r, pgm_r, lat_r};
    wire  [7:0] stat_rd = {5'h00, busy, state_r};
    wire  [7:0] rd_nxt  =
        (haddr_i[7:0] == `ETB_ADDR_CTRL)    ? ctrl_rd   :
        (haddr_i[7:0] == `ETB_ADDR_ACR)     ? acr_r     :
        (haddr_i[7:0] == `ETB_ADDR_OPT_NV)  ? opt_nv_r  :
        (haddr_i[7:0] == `ETB_ADDR_DIVH)    ? divh_r    :
        (haddr_i[7:0] == `ETB_ADDR_DIVL)    ? divl_r    :
        (haddr_i[7:0] == `ETB_ADDR_DIVH_NV) ? divh_nv_r :
        (haddr_i[7:0] == `ETB_ADDR_DIVL_NV) ? divl_nv_r :
        (haddr_i[7:0] == `ETB_ADDR_STATUS)  ? stat_rd   :
        (haddr_i[7:0] == `ETB_ADDR_SEQ_LEN) ? seq_len_r : 8'h00;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            rd_r <= 8'h00;
        else if (addr_ph && !hwrite_i)
            rd_r <= rd_nxt;
    end

    assign hrdata_o         = {24'h00_0000, rd_r};
    assign hreadyout_o      = 1'b1;
    assign hresp_o          = 1'b0;
    assign tick_o           = tick_r;
    assign high_voltage_o   = (state_r == ETB_RUN) && pgm_r && lat_r;
    assign block_protect_o  = acr_r[3:0];
    assign array_secure_o   = !acr_r[4];
    assign access_blocked_o = busy;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_div_locked: assert property (@(posedge clk_i) disable iff (rst_i)
        (!sec_off && !load_r) |=> $stable(divh_r) && $stable(divl_r))
        else $error("Divider changed while locked");
    a_acr_load: assert property (@(posedge clk_i) disable iff (rst_i)
        load_r |=> (acr_r == $past(opt_nv_r)))
        else $error("Config not loaded");
    a_hv_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        high_voltage_o |-> lat_r && valid_r)
        else $error("High voltage without capture");
    a_halt_no_hv: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ETB_HALT) |-> !high_voltage_o && access_blocked_o)
        else $error("Voltage during stop");
    a_tick_reload: assert property (@(posedge clk_i) disable iff (rst_i)
        tb_exp |=> (tb_cnt_r == $past(divisor)) && tick_o)
        else $error("Timebase not reloaded");
    a_abort_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ETB_RUN && stop_mode_i && !pgm_r) |=> state_r == ETB_IDLE)
        else $error("Sequence not terminated");
    a_wait_free: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == ETB_RUN && wait_mode_i && !stop_mode_i && !seq_done)
        |=> state_r == ETB_RUN)
        else $error("Wait disturbed sequence");
    a_div_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_en && wa_r == `ETB_ADDR_DIVL && lat_r && !load_r) |=> $stable(divl_r))
        else $error("Divider written while latched");
endmodule
`default_nettype wire

// *** verification/etb_timebase_config_tb_top.sv ***
`include "etb_defs.svh"
`default_nettype none
module etb_timebase_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------
    // Signals
    // ------------------------------
    logic        clk_i;
    logic        rst_i;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hresp;
    logic        xtal_en;
    logic        wait_m;
    logic        stop_m;
    logic        tick;
    logic        hv;
    logic [3:0]  bprot;
    logic        asec;
    logic        blocked;
    int          fails;
    int          checks;

    etb_timebase_config u_etb_timebase_config
    (
        .clk_i            (clk_i),
        .rst_i            (rst_i),
        .hsel_i           (hsel),
        .haddr_i          (haddr),
        .htrans_i         (htrans),
        .hwrite_i         (hwrite),
        .hsize_i          (hsize),
        .hwdata_i         (hwdata),
        .hready_i         (hready),
        .hrdata_o         (hrdata),
        .hreadyout_o      (hready),
        .hresp_o          (hresp),
        .xtal_ref_en_i    (xtal_en),
        .wait_mode_i      (wait_m),
        .stop_mode_i      (stop_m),
        .tick_o           (tick),
        .high_voltage_o   (hv),
        .block_protect_o  (bprot),
        .array_secure_o   (asec),
        .access_blocked_o (blocked)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_i);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        chk(name, exp, x);
    endtask

    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic wait_hv;
        int n;
        n = 0;
        while (hv !== 1'b0 && n < 600)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("high_voltage_end", 32'h0000_0000, {31'h0, hv});
    endtask

    task automatic prog(input logic [7:0] a, input logic [31:0] d, input bit ok);
        wr(`ETB_ADDR_CTRL, 32'h0000_0009);
        wr(a, d);
        wr(`ETB_ADDR_CTRL, 32'h0000_000B);
        @(posedge clk_i);
        if (ok)
        begin
            chk("high_voltage_on", 32'h0000_0001, {31'h0, hv});
            wait_hv();
        end
        else
            repeat (60) @(posedge clk_i);
        wr(`ETB_ADDR_CTRL, 32'h0000_0008);
        wr(`ETB_ADDR_CTRL, 32'h0000_0008);
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_reset;
        rd("config", `ETB_ADDR_ACR, 32'h0000_00F0);
        rd("options_nv", `ETB_ADDR_OPT_NV, 32'h0000_00F0);
        rd("div_high", `ETB_ADDR_DIVH, 32'h0000_0080);
        rd("div_low", `ETB_ADDR_DIVL, 32'h0000_0000);
        chk("block_protect", 32'h0000_0000, {28'h000_0000, bprot});
        rd("unmapped", 8'h40, 32'h0000_0000);
        chk("response", 32'h0000_0000, {31'h0, hresp});
        $display("test reset done");
    endtask

    task automatic t_divider;
        int n;
        wr(`ETB_ADDR_DIVH, 32'h0000_0085);
        wr(`ETB_ADDR_DIVL, 32'h0000_00AC);
        rd("div_high_100mhz", `ETB_ADDR_DIVH, 32'h0000_0085);
        rd("div_low_100mhz", `ETB_ADDR_DIVL, 32'h0000_00AC);
        wr(`ETB_ADDR_DIVH, 32'h0000_0080);
        wr(`ETB_ADDR_DIVL, 32'h0000_0005);
        rd("div_low_wr", `ETB_ADDR_DIVL, 32'h0000_0005);
        wr(`ETB_ADDR_CTRL, 32'h0000_0008);
        n = 0;
        while (tick !== 1'b1 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        @(posedge clk_i);
        n = 1;
        while (tick !== 1'b1 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("tick_period", 32'h0000_0005, n);
        wr(`ETB_ADDR_CTRL, 32'h0000_0009);
        wr(`ETB_ADDR_DIVL, 32'h0000_0033);
        rd("div_low_latched", `ETB_ADDR_DIVL, 32'h0000_0005);
        wr(`ETB_ADDR_CTRL, 32'h0000_0008);
        $display("test divider done");
    endtask

    task automatic t_program;
        wait_m <= 1'b1;
        prog(`ETB_ADDR_OPT_NV, 32'h0000_00F3, 1'b1);
        wait_m <= 1'b0;
        rd("options_nv_new", `ETB_ADDR_OPT_NV, 32'h0000_00F3);
        do_reset();
        rd("config_new", `ETB_ADDR_ACR, 32'h0000_00F3);
        chk("block_protect_new", 32'h0000_0003, {28'h000_0000, bprot});
        chk("array_secure", 32'h0000_0000, {31'h0, asec});
        $display("test program done");
    endtask

    task automatic t_stop;
        wr(`ETB_ADDR_DIVL, 32'h0000_0020);
        wr(`ETB_ADDR_CTRL, 32'h0000_0009);
        wr(`ETB_ADDR_DIVL_NV, 32'h0000_0007);
        wr(`ETB_ADDR_CTRL, 32'h0000_000B);
        repeat (2) @(posedge clk_i);
        stop_m <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("hv_in_stop", 32'h0000_0000, {31'h0, hv});
        chk("blocked_in_stop", 32'h0000_0001, {31'h0, blocked});
        stop_m <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("hv_after_stop", 32'h0000_0001, {31'h0, hv});
        wait_hv();
        wr(`ETB_ADDR_CTRL, 32'h0000_0008);
        wr(`ETB_ADDR_CTRL, 32'h0000_0008);
        rd("div_low_nv", `ETB_ADDR_DIVL_NV, 32'h0000_0007);
        $display("test stop done");
    endtask

    task automatic t_secure;
        prog(`ETB_ADDR_DIVH_NV, 32'h0000_0000, 1'b1);
        do_reset();
        rd("div_high_sec", `ETB_ADDR_DIVH, 32'h0000_0000);
        rd("div_low_rst", `ETB_ADDR_DIVL, 32'h0000_0007);
        wr(`ETB_ADDR_DIVL, 32'h0000_0022);
        rd("div_low_lock", `ETB_ADDR_DIVL, 32'h0000_0007);
        wr(`ETB_ADDR_DIVH, 32'h0000_0080);
        rd("div_high_lock", `ETB_ADDR_DIVH, 32'h0000_0000);
        prog(`ETB_ADDR_DIVL_NV, 32'h0000_0011, 1'b0);
        rd("div_low_nv_lock", `ETB_ADDR_DIVL_NV, 32'h0000_0007);
        $display("test secure done");
    endtask

    // ------------------------------
    // Main sequence and watchdog
    // ------------------------------
    initial
    begin
        fails = 0;
        checks = 0;
        rst_i = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        xtal_en = 1'b0;
        wait_m = 1'b0;
        stop_m = 1'b0;
        do_reset();
        t_reset();
        t_divider();
        t_program();
        t_stop();
        t_secure();
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        fails++;
        $display("watchdog expired");
        finish_test();
    end
endmodule
`default_nettype wire
